// ### uwl_defines.svh
`ifndef UWL_DEFINES_SVH
`define UWL_DEFINES_SVH

`define OPC_LEFT      6'h22
`define OPC_RIGHT     6'h26
`define OPC_MSB       31
`define OPC_LSB       26
`define BASE_MSB      25
`define BASE_LSB      21
`define DEST_MSB      20
`define DEST_LSB      16
`define OFFS_MSB      15
`define OFFS_LSB      0
`define SIGN_BIT      31
`define RESET_DATA    64'h0000_0000_0000_0000
`define RESET_REG     5'h00
// upper half on a partial right load: 1 = copy bit 31, 0 = keep
`define RIGHT_SIGN_PARTIAL 1'b0

`endif

// ### uwl_pkg.sv
package uwl_pkg;
  typedef enum logic [1:0] {LD_NONE, LD_LEFT, LD_RIGHT} ld_kind_e;

  typedef struct packed {
    ld_kind_e    kind;
    logic [4:0]  baseReg;
    logic [4:0]  destReg;
    logic [15:0] offset;
  } instr_s;

  typedef struct packed {
    logic tlbRefill;
    logic tlbInvalid;
    logic busError;
    logic addrError;
  } exc_s;

  typedef struct packed {
    logic        cpuBigEndian;
    logic        memBigEndian;
    logic        reverseOrder;
    logic        mode64;
  } mode_s;
endpackage

// ### uwl_decode.sv
`timescale 1ns/1ps
`include "uwl_defines.svh"

module uwl_decode (
  input  wire logic [31:0]    instrWord,
  output uwl_pkg::instr_s     instr
);
  always_comb begin
    instr.baseReg = instrWord[`BASE_MSB:`BASE_LSB];
    instr.destReg = instrWord[`DEST_MSB:`DEST_LSB];
    instr.offset  = instrWord[`OFFS_MSB:`OFFS_LSB];
    case (instrWord[`OPC_MSB:`OPC_LSB])
      `OPC_LEFT:  instr.kind = uwl_pkg::LD_LEFT;   // [RULE_01]
      `OPC_RIGHT: instr.kind = uwl_pkg::LD_RIGHT;  // [RULE_10]
      default:    instr.kind = uwl_pkg::LD_NONE;
    endcase
  end
endmodule // uwl_decode

// ### uwl_lane_merge.sv
`timescale 1ns/1ps
`include "uwl_defines.svh"

module uwl_lane_merge (
  input  wire logic [31:0]    memWord,
  input  wire logic [63:0]    oldValue,
  input  wire logic [1:0]     addrLow,
  input  wire logic           isLeft,
  input  wire uwl_pkg::mode_s mode,
  output logic [63:0]         merged
);
  logic [1:0]  byteIdx;
  logic [31:0] rotated;
  logic [3:0]  laneSel;
  logic [31:0] low;
  logic        fullWord;

  // rotate a word left by n whole bytes (lane i moves to lane i+n, wrapping)
  function automatic logic [31:0] rotl8(input logic [31:0] w, input logic [1:0] n);
    logic [63:0] d;
    d = {w, w} << {n, 3'b000};
    return d[63:32];
  endfunction

  always_comb begin
    byteIdx = addrLow ^ {2{mode.cpuBigEndian}};  // [RULE_14]
    // byteIdx: little-endian byte number of the addressed byte
    if (isLeft) begin
      // addressed byte goes to lane 3; lanes 3..3-byteIdx written
      rotated = rotl8(memWord, 2'd3 - byteIdx);  // [RULE_16]
      laneSel = 4'b1000 | ({4{byteIdx >= 2'd1}} & 4'b0100)  // [RULE_05] [RULE_06]
              | ({4{byteIdx >= 2'd2}} & 4'b0010) | ({4{byteIdx == 2'd3}} & 4'b0001);
      fullWord = 1'b1;                            // [RULE_04]
    end else begin
      // addressed byte goes to lane 0; lanes 0..3-byteIdx written
      rotated = rotl8(memWord, 2'd0 - byteIdx);  // [RULE_16]
      laneSel = 4'b0001 | ({4{byteIdx <= 2'd2}} & 4'b0010)  // [RULE_15]
              | ({4{byteIdx <= 2'd1}} & 4'b0100) | ({4{byteIdx == 2'd0}} & 4'b1000);
      fullWord = (byteIdx == 2'd0);               // [RULE_12]
    end
    for (int i = 0; i < 4; i++) begin
      low[8*i +: 8] = laneSel[i] ? rotated[8*i +: 8] : oldValue[8*i +: 8];  // [RULE_03] [RULE_11]
    end
    if (!mode.mode64)
      merged = {32'h0000_0000, low};
    else if (fullWord || `RIGHT_SIGN_PARTIAL)
      merged = {{32{low[`SIGN_BIT]}}, low};       // [RULE_04] [RULE_12] [RULE_13]
    else
      merged = {oldValue[63:32], low};
  end
endmodule // uwl_lane_merge

// ### unaligned_word_load_merge.sv
`timescale 1ns/1ps
`include "uwl_defines.svh"
// Operation
// [RULE_01] decode left load fields and opcode
// [RULE_02] address is sign-extended offset plus base
// [RULE_03] left load fills upper bytes, keeps rest
// [RULE_04] 64-bit left load sign-extends bit 31
// [RULE_05] big-endian left load byte count by offset
// [RULE_06] little-endian left load byte count by offset
// [RULE_07] forward previous load result into merge
// [RULE_08] software avoids using destination next instruction
// [RULE_09] access faults reported, no alignment fault
// [RULE_10] decode right load with same layout
// [RULE_11] right load fills lower bytes, keeps rest
// [RULE_12] right load sign-extends only full word
// [RULE_13] left plus right gives sign-extended word
// [RULE_14] selection uses address low bits, order
// [RULE_15] big-endian right load byte count by offset
// [RULE_16] one lane merge datapath with rotator
// [RULE_17] endian flags adjust physical address bits

module unaligned_word_load_merge (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic            issue,
  input  wire logic [31:0]     instrWord,
  input  wire uwl_pkg::mode_s  mode,
  output logic [4:0]           baseSel,
  input  wire logic [63:0]     baseValue,
  output logic [4:0]           destSel,
  input  wire logic [63:0]     destValue,
  output logic                 memReq,
  output logic [63:0]          virtAddr,
  input  wire logic [31:0]     physAddrIn,
  output logic [31:0]          physAddr,
  input  wire logic            memValid,
  input  wire logic [31:0]     memWord,
  input  wire uwl_pkg::exc_s   accessExc,
  output logic                 busy,
  output logic                 wbValid,
  output logic [4:0]           wbReg,
  output logic [63:0]          wbData,
  output logic                 excValid,
  output uwl_pkg::exc_s        excCause
);
  typedef enum logic [1:0] {IDLE, WAIT_MEM} state_e;

  state_e           state;
  uwl_pkg::instr_s  dec;
  uwl_pkg::instr_s  held;
  logic [63:0]      next_addr;
  logic [1:0]       addrLow;
  logic [63:0]      oldValue;
  logic [63:0]      merged;
  logic             accept;
  logic             excAny;

  uwl_decode u_decode (
    .instrWord (instrWord),
    .instr     (dec)
  );

  assign accept  = issue && (state == IDLE) && (dec.kind != uwl_pkg::LD_NONE);
  assign baseSel = dec.baseReg;
  assign destSel = held.destReg;
  assign busy    = (state != IDLE);
  assign memReq  = (state == WAIT_MEM);
  assign excAny  = accessExc.tlbRefill | accessExc.tlbInvalid
                 | accessExc.busError | accessExc.addrError;

  always_comb begin
    next_addr = baseValue + {{48{dec.offset[15]}}, dec.offset};  // [RULE_02]
  end

  // word select bits of the physical address under the endian flags
  always_comb begin
    physAddr = physAddrIn;
    physAddr[1:0] = physAddrIn[1:0] ^ {2{mode.reverseOrder}};  // [RULE_17]
    if (!mode.memBigEndian)
      physAddr[1:0] = 2'b00;                                    // [RULE_17]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE:     if (accept) state <= WAIT_MEM;
        WAIT_MEM: if (memValid || excAny) state <= IDLE;
        default:  state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      held     <= '{kind: uwl_pkg::LD_NONE, baseReg: `RESET_REG, destReg: `RESET_REG,
                    offset: 16'h0000};
      virtAddr <= `RESET_DATA;
    end else if (accept) begin
      held     <= dec;
      virtAddr <= next_addr;  // [RULE_09] no alignment check on the address
    end
  end

  assign addrLow = virtAddr[1:0];

  // forward the just-written result when the previous load hit the same register
  always_comb begin
    if (wbValid && wbReg == held.destReg)
      oldValue = wbData;  // [RULE_07]
    else
      oldValue = destValue;
  end

  uwl_lane_merge u_merge (
    .memWord  (memWord),
    .oldValue (oldValue),
    .addrLow  (addrLow),
    .isLeft   (held.kind == uwl_pkg::LD_LEFT),
    .mode     (mode),
    .merged   (merged)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wbValid <= 1'b0;
      wbReg   <= `RESET_REG;
      wbData  <= `RESET_DATA;
    end else begin
      wbValid <= (state == WAIT_MEM) && memValid && !excAny;
      if ((state == WAIT_MEM) && memValid && !excAny) begin
        wbReg  <= held.destReg;
        wbData <= merged;  // [RULE_03] [RULE_11] [RULE_16]
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      excValid <= 1'b0;
      excCause <= '0;
    end else begin
      excValid <= (state == WAIT_MEM) && excAny;  // [RULE_09]
      if ((state == WAIT_MEM) && excAny)
        excCause <= accessExc;
    end
  end

  // assertions
  logic [1:0]  bIdx;
  logic        wasLeft;
  logic [31:0] prevOld;
  logic [31:0] prevMem;
  logic [31:0] prevOldHi;
  logic        was64;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prevOldHi <= 32'h0000_0000;
      was64     <= 1'b0;
      wasLeft <= 1'b0;
      bIdx    <= 2'b00;
      prevOld <= 32'h0000_0000;
      prevMem <= 32'h0000_0000;
    end else begin
      wasLeft <= (held.kind == uwl_pkg::LD_LEFT);
      bIdx    <= addrLow ^ {2{mode.cpuBigEndian}};
      prevOld <= oldValue[31:0];
      prevMem <= memWord;
      prevOldHi <= oldValue[63:32];
      was64     <= mode.mode64;
    end
  end

  sequence s_load_done;
    (state == WAIT_MEM) && memValid && !excAny;
  endsequence

  a_wb_follows: assert property (@(posedge clk) disable iff (!nrst)
    s_load_done |=> wbValid) else $error("write-back missing after data");  // [RULE_03]
  a_exc_no_wb: assert property (@(posedge clk) disable iff (!nrst)
    (state == WAIT_MEM) && excAny |=> excValid && !wbValid)
    else $error("fault not reported");  // [RULE_09]
  a_no_align_fault: assert property (@(posedge clk) disable iff (!nrst)
    accept && !excAny |=> !excValid) else $error("alignment fault raised");  // [RULE_09]
  a_addr_sum: assert property (@(posedge clk) disable iff (!nrst)
    accept |=> virtAddr == $past(next_addr)) else $error("bad effective address");  // [RULE_02]
  a_left_sign: assert property (@(posedge clk) disable iff (!nrst)
    s_load_done ##1 (wasLeft && mode.mode64) |-> wbData[63:32] == {32{wbData[31]}})
    else $error("left load not sign extended");  // [RULE_04]
  a_left_top: assert property (@(posedge clk) disable iff (!nrst)
    s_load_done ##1 wasLeft |-> wbData[31:24] == prevMem[8*bIdx +: 8])
    else $error("left top byte wrong");  // [RULE_05] [RULE_06]
  a_right_bottom: assert property (@(posedge clk) disable iff (!nrst)
    s_load_done ##1 !wasLeft |-> wbData[7:0] == prevMem[8*bIdx +: 8])
    else $error("right low byte wrong");  // [RULE_15]
  a_left_keep: assert property (@(posedge clk) disable iff (!nrst)
    s_load_done ##1 (wasLeft && bIdx == 2'd0) |-> wbData[23:0] == prevOld[23:0])
    else $error("left load changed low bytes");  // [RULE_03]
  a_right_keep: assert property (@(posedge clk) disable iff (!nrst)
    s_load_done ##1 (!wasLeft && bIdx == 2'd3) |-> wbData[31:8] == prevOld[31:8])
    else $error("right load changed high bytes");  // [RULE_11]
  a_phys_le: assert property (@(posedge clk) disable iff (!nrst)
    !mode.memBigEndian |-> physAddr[1:0] == 2'b00) else $error("word address not aligned");  // [RULE_17]

  // handshake with the memory side
  a_req_after_take: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_01]
    accept |=> memReq)
    else $error("no memory request after a taken load");

  a_req_holds: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_09]
    memReq && !memValid && !excAny |=> memReq)
    else $error("memory request dropped early");

  a_req_drops: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_09]
    memReq && (memValid || excAny) |=> !memReq)
    else $error("memory request held after answer");

  a_none_ignored: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_10]
    (state == IDLE) && !accept |=> !busy)
    else $error("busy without a taken load");

  a_held_stable: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_16]
    (state == WAIT_MEM) |=> held == $past(held))
    else $error("held instruction changed while busy");

  a_addr_stable: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_02]
    (state == WAIT_MEM) |=> virtAddr == $past(virtAddr))
    else $error("address changed while busy");

  a_base_field: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_01]
    baseSel == instrWord[`BASE_MSB:`BASE_LSB])
    else $error("base select not from base field");

  // result and fault pulses
  a_wb_pulse: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_03]
    wbValid |=> !wbValid)
    else $error("write-back longer than one cycle");

  a_exc_pulse: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_09]
    excValid |=> !excValid)
    else $error("fault pulse longer than one cycle");

  a_wb_exclusive: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_09]
    !(wbValid && excValid))
    else $error("write-back and fault together");

  a_exc_idle: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_09]
    excValid |-> !memReq)
    else $error("still requesting after a fault");

  a_wb_idle: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_07]
    wbValid |-> (state == IDLE))
    else $error("busy during write-back");

  a_wb_reg_dest: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_01]
    s_load_done |=> wbReg == $past(held.destReg))
    else $error("write-back to wrong register");

  a_exc_cause: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_09]
    (state == WAIT_MEM) && excAny |=> excCause == $past(accessExc))
    else $error("fault cause not kept");

  // merged word against the byte tables
  a_narrow_upper: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_04]
    s_load_done ##1 !was64 |-> wbData[63:32] == 32'h0000_0000)
    else $error("upper half not zero in 32-bit mode");

  a_right_full_sign: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_12]
    s_load_done ##1 (!wasLeft && was64 && bIdx == 2'd0) |-> wbData[63:32] == {32{wbData[31]}})
    else $error("full right load not sign extended");

  a_right_part_keep: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_12]
    s_load_done ##1 (!wasLeft && was64 && bIdx != 2'd0) |-> wbData[63:32] == prevOldHi)
    else $error("partial right load changed upper half");

  a_left_full: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_05] [RULE_06]
    s_load_done ##1 (wasLeft && bIdx == 2'd3) |-> wbData[31:0] == prevMem)
    else $error("full left load wrong");

  a_right_full: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_15]
    s_load_done ##1 (!wasLeft && bIdx == 2'd0) |-> wbData[31:0] == prevMem)
    else $error("full right load wrong");

  a_left_half: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_05] [RULE_06]
    s_load_done ##1 (wasLeft && bIdx == 2'd1) |-> wbData[31:0] == {prevMem[15:0], prevOld[15:0]})
    else $error("two-byte left load wrong");

  a_right_half: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_15]
    s_load_done ##1 (!wasLeft && bIdx == 2'd2) |-> wbData[31:0] == {prevOld[31:16], prevMem[31:16]})
    else $error("two-byte right load wrong");

  // physical word address under the byte order flags
  a_phys_be: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_17]
    mode.memBigEndian |-> physAddr[1:0] == (physAddrIn[1:0] ^ {2{mode.reverseOrder}}))
    else $error("word select bits not reversed");

  a_phys_upper: assert property (@(posedge clk) disable iff (!nrst)  // [RULE_17]
    physAddr[31:2] == physAddrIn[31:2])
    else $error("upper address bits changed");
endmodule // unaligned_word_load_merge

// ### mem_model.sv
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        memReq,
  input  wire logic [31:0] data,
  input  wire logic [2:0]  delay,
  output logic             memValid,
  output logic [31:0]      memWord
);
  logic [2:0] cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt      <= 3'h0;
      memValid <= 1'b0;
      memWord  <= 32'h0000_0000;
    end else if (memReq && !memValid && cnt == delay) begin
      memValid <= 1'b1;
      memWord  <= data;
    end else begin
      cnt      <= (memReq && !memValid) ? cnt + 3'h1 : 3'h0;
      memValid <= 1'b0;
      // word inverted on every cycle that does not deliver data
      memWord  <= ~memWord;
    end
  end
endmodule // mem_model

// ### unaligned_word_load_merge_test.sv
`timescale 1ns/1ps
`include "uwl_defines.svh"
module unaligned_word_load_merge_test;
  logic           clk = 1'b0;
  logic           nrst = 1'b0;
  logic           issue = 1'b0;
  logic [31:0]    instrWord = 32'h0000_0000;
  uwl_pkg::mode_s mode = 4'h0;
  logic [63:0]    regs [32];
  logic [31:0]    physAddrIn = 32'h0000_0000;
  logic [31:0]    memData = 32'h8C5A_F31E;
  logic [2:0]     delay = 3'h0;
  uwl_pkg::exc_s  accessExc = 4'h0;
  uwl_pkg::exc_s  excCause;
  logic [4:0]     baseSel, destSel, wbReg;
  logic           memReq, memValid, busy, wbValid, excValid;
  logic [63:0]    virtAddr, wbData;
  logic [31:0]    physAddr, memWord;
  int             badCount = 0;
  int             cmpCount = 0;
  int             cycles = 0;

  always #2.5 clk = ~clk;

  unaligned_word_load_merge u_unaligned_word_load_merge (
    .clk(clk), .nrst(nrst), .issue(issue), .instrWord(instrWord), .mode(mode),
    .baseSel(baseSel), .baseValue(regs[baseSel]), .destSel(destSel),
    .destValue(regs[destSel]), .memReq(memReq), .virtAddr(virtAddr),
    .physAddrIn(physAddrIn), .physAddr(physAddr), .memValid(memValid),
    .memWord(memWord), .accessExc(accessExc), .busy(busy), .wbValid(wbValid),
    .wbReg(wbReg), .wbData(wbData), .excValid(excValid), .excCause(excCause)
  );

  mem_model u_mem_model (
    .clk(clk), .nrst(nrst), .memReq(memReq), .data(memData), .delay(delay),
    .memValid(memValid), .memWord(memWord)
  );

  always @(posedge clk) begin
    if (wbValid) regs[wbReg] <= wbData;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      reportAndStop();
    end
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [63:0] merge(input logic left, input logic [1:0] off,
      input uwl_pkg::mode_s m, input logic [63:0] old, input logic [31:0] mem);
    logic [1:0]  b;
    logic [31:0] lo;
    logic [31:0] hi;
    b = off ^ {2{m.cpuBigEndian}};
    if (left) lo = (mem << (8 * (3 - b))) | (old[31:0] & ~(32'hFFFF_FFFF << (8 * (3 - b))));
    else lo = (mem >> (8 * b)) | (old[31:0] & ~(32'hFFFF_FFFF >> (8 * b)));
    hi = (left || b == 2'h0) ? {32{lo[31]}} : old[63:32];
    return m.mode64 ? {hi, lo} : {32'h0000_0000, lo};
  endfunction

  task automatic waitDone();
    for (int n = 0; n < 20 && wbValid !== 1'b1 && excValid !== 1'b1; n++) @(negedge clk);
  endtask

  task automatic load(input logic left, input logic [4:0] dest, input logic [15:0] off);
    logic [63:0] eff;
    logic [63:0] old;
    eff = regs[1] + {{48{off[15]}}, off};
    @(posedge clk);
    issue     <= 1'b1;
    instrWord <= {left ? `OPC_LEFT : `OPC_RIGHT, 5'h01, dest, off};
    @(posedge clk);
    issue <= 1'b0;
    @(negedge clk);
    old = regs[dest];
    chk("virtAddr", eff, virtAddr);
    waitDone();
    if (accessExc !== 4'h0) begin
      chk("excCause", {60'h0, accessExc}, {60'h0, excCause});
      chk("excValid", 64'h1, {63'h0, excValid});
      chk("wbValid", 64'h0, {63'h0, wbValid});
    end else begin
      chk("wbReg", {59'h0, dest}, {59'h0, wbReg});
      chk("wbData", merge(left, eff[1:0], mode, old, memData), wbData);
    end
  endtask

  task automatic mergeAll();
    for (int k = 0; k < 8; k++) begin
      for (int o = 0; o < 4; o++) begin
        @(posedge clk);
        mode  <= {k[1], 1'b1, 1'b0, k[2]};
        delay <= o[2:0];
        regs[5] = 64'h1234_5678_9ABC_DEF0;
        load(k[0], 5'h05, 16'hFFFC + o[15:0]);
      end
    end
  endtask

  task automatic pairLoad();
    logic [63:0] exp;
    regs[6] = 64'h0000_0000_0000_0000;
    @(posedge clk);
    mode      <= 4'hD;
    issue     <= 1'b1;
    instrWord <= {`OPC_LEFT, 5'h01, 5'h06, 16'h0002};
    @(posedge clk);
    // offered while busy; taken once the left load completes
    instrWord <= {`OPC_RIGHT, 5'h01, 5'h06, 16'h0005};
    waitDone();
    @(posedge clk);
    issue <= 1'b0;
    @(negedge clk);
    waitDone();
    exp = merge(1'b0, 2'h1, 4'hD, merge(1'b1, 2'h2, 4'hD, 64'h0, memData), memData);
    chk("pair", exp, wbData);
  endtask

  task automatic faults();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      accessExc <= 4'h1 << i;
      load(1'b1, 5'h07, 16'h0003);
      @(posedge clk);
      accessExc <= 4'h0;
    end
  endtask

  task automatic physMap();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      mode       <= {1'b0, i[1:0], 1'b0};
      physAddrIn <= 32'h0000_1237;
      @(negedge clk);
      chk("physAddr", {32'h0, 30'h48D, i[1] ? 2'h3 ^ {2{i[0]}} : 2'h0}, {32'h0, physAddr});
    end
  endtask

  task automatic ignoreOther();
    @(posedge clk);
    issue     <= 1'b1;
    instrWord <= 32'h8C22_0000;
    @(posedge clk);
    issue <= 1'b0;
    @(negedge clk);
    chk("busy", 64'h0, {63'h0, busy});
  endtask

  task automatic reportAndStop();
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    foreach (regs[i]) regs[i] = 64'h0000_0000_0000_0000;
    regs[1] = 64'h0000_0000_0000_1000;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    mergeAll();
    pairLoad();
    faults();
    physMap();
    ignoreOther();
    reportAndStop();
  end
endmodule // unaligned_word_load_merge_test
